// File: rst_pwr_pkg.sv
// constants for the reset status and power mode controller
`default_nettype none
package rst_pwr_pkg;
   localparam logic [7:0] ADDR_POWER_CTRL    = 8'h87;
   localparam logic [7:0] ADDR_CAUSE_FLAGS   = 8'h97;
   localparam logic [7:0] ADDR_DETECTOR_CTRL = 8'h44;
   localparam logic [7:0] ADDR_WDT_CTRL      = 8'hE1;
   localparam logic [7:0] ADDR_SYSFLAG_IE    = 8'hE2;
   localparam logic [7:0] ADDR_CLOCK_CTRL    = 8'hE3;
   localparam int BIT_WDT_FLAG   = 0;
   localparam int BIT_FBO_FLAG   = 1;
   localparam int BIT_SBO_FLAG   = 2;
   localparam int BIT_RTC_FLAG   = 4;
   localparam int BIT_EXT_FLAG   = 6;
   localparam int BIT_SOFT_FLAG  = 7;
   localparam int BIT_IDLE       = 0;
   localparam int BIT_PDOWN      = 1;
   localparam int BIT_FBO_RE     = 1;
   localparam int BIT_SBO_EN     = 2;
   localparam int BIT_SBO_RE     = 3;
   localparam int BIT_AWAKE_PD   = 7;
   localparam int BIT_WDT_NONSTOP = 6;
   localparam int BIT_WDT_RE     = 7;
   localparam int BIT_SYSFLAG_IE = 0;
   localparam int BIT_FBO_IE     = 1;
   localparam int BIT_SBO_IE     = 2;
   localparam logic [7:0] CAUSE_WMASK     = 8'hD7;
   localparam logic [7:0] RST_CAUSE       = 8'h00;
   localparam logic [7:0] RST_POWER_CTRL  = 8'h00;
   localparam logic [7:0] RST_DETECTOR    = 8'h05;
   localparam logic [7:0] RST_WDT_CTRL    = 8'h00;
   localparam logic [7:0] RST_SYSFLAG_IE  = 8'h00;
   localparam logic [7:0] RST_CLOCK_CTRL  = 8'h00;
   localparam logic [7:0] DETECTOR_FIXED  = 8'h01;
   localparam logic [7:0] DETECTOR_WMASK  = 8'hBE;
   localparam int CLK_MHZ        = 25;
   localparam int WAKE_COUNT     = 1024;
   localparam int RESET_PULSE    = 4;
   localparam int REENTRY_NS     = 4000;
   localparam int REENTRY_CYCLES = (REENTRY_NS * CLK_MHZ + 999) / 1000;
endpackage
`default_nettype wire

// File: rst_pwr_ctrl.sv
// reset sources, cause flags, brown-out handling and power modes
// How it works
// - watchdog overflow while running sets cause flag bit zero
// - reset-enable bit makes overflow reset the cpu
// - cause flag: hardware set, write-one clear
// - illegal fetch address forces system reset
// - fixed brown-out flag, gated interrupt
// - selectable brown-out likewise, wakes when awake-bit set
// - fixed detector reset when its enable set
// - selectable reset; in power-down needs awake bit
// - detector enable off silences selectable detector
// - nonzero divider select slows cpu clock
// - oscillator select picks low-speed rc source
// - rtc overflow wakes from power-down when its wake enable set
// - nonstop watchdog runs and wakes in power-down
// - awake detector monitors and wakes in power-down
// - idle halts cpu clock, pins hold
// - peripherals keep running during idle
// - interrupt or reset ends idle
// - power-down stops oscillator and flash
// - power-down exits on listed sources; a system reset goes straight to run unless its source also wakes or the wake count is already running
// - idle and power-down bits auto-clear on exit
// - wake counter runs full before cpu clock
// - edge interrupts forced level in power-down
`default_nettype none
module rst_pwr_ctrl
   import rst_pwr_pkg::*;
(
   input  wire logic       core_clk_i,
   input  wire logic       rstn_i,
   input  wire logic       clk_en_i,
   input  wire logic       sfr_wr_i,
   input  wire logic       sfr_rd_i,
   input  wire logic [7:0] sfr_addr_i,
   input  wire logic [7:0] sfr_wdata_i,
   input  wire logic       ext_reset_i,
   input  wire logic       soft_reset_i,
   input  wire logic       illegal_addr_i,
   input  wire logic       wdt_overflow_i,
   input  wire logic       wdt_running_i,
   input  wire logic       rtc_overflow_i,
   input  wire logic       rtc_wake_en_i,
   input  wire logic       fixed_brownout_i,
   input  wire logic       selectable_brownout_i,
   input  wire logic       ext_int_wake_i,
   input  wire logic       keypad_wake_i,
   input  wire logic       any_int_i,
   output logic [7:0]      sfr_rdata_o,
   output logic            sys_reset_o,
   output logic            cpu_clk_gate_o,
   output logic            osc_stop_o,
   output logic            flash_pwr_down_o,
   output logic            pins_hold_o,
   output logic            force_level_int_o,
   output logic            sysflag_irq_o,
   output logic            wdt_run_o,
   output logic [2:0]      clk_div_sel_o,
   output logic [1:0]      osc_src_sel_o,
   output logic [1:0]      sbo_level_o
);
   // ****************************************
   // state
   // ****************************************
   typedef enum {RUN, IDLE, PDOWN, WAKE} mode_t;
   typedef struct packed {
      logic [1:0]  ext_s1, ext_s2, fbo_s1, fbo_s2, sbo_s1, sbo_s2;
      logic [7:0]  cause;
      logic [7:0]  pwr;
      logic [7:0]  det;
      logic [7:0]  wdtc;
      logic [7:0]  system_flag_int_enable_reg;
      logic [7:0]  clkc;
      logic [7:0]  rdata;
      logic [10:0] cnt;
      logic [2:0]  rst_cnt;
      logic        srst, gate, osc, flash, hold, lvl, irq, wrun;
   } state_t;
   state_t s_q, s_d;
   mode_t  mode_q, mode_d;

   function automatic logic hit(input logic [7:0] a);
      hit = sfr_wr_i && (sfr_addr_i == a);
   endfunction

   logic ext_r, fbo_r, sbo_r, in_pd, sbo_live, fbo_ev, sbo_ev, wake_pd, rst_req;

   always_comb begin
      s_d    = s_q;
      mode_d = mode_q;
      // pins are async: second stage only is read
      s_d.ext_s1 = {ext_reset_i, 1'b0};
      s_d.ext_s2 = s_q.ext_s1;
      s_d.fbo_s1 = {fixed_brownout_i, 1'b0};
      s_d.fbo_s2 = s_q.fbo_s1;
      s_d.sbo_s1 = {selectable_brownout_i, 1'b0};
      s_d.sbo_s2 = s_q.sbo_s1;
      ext_r = s_q.ext_s2[1];
      fbo_r = s_q.fbo_s2[1];
      sbo_r = s_q.sbo_s2[1];
      in_pd = (mode_q == PDOWN) || (mode_q == WAKE);
      sbo_live = s_q.det[BIT_SBO_EN] && (!in_pd || s_q.det[BIT_AWAKE_PD]);
      fbo_ev = fbo_r && !in_pd;
      sbo_ev = sbo_r && sbo_live;
      rst_req = ext_r || soft_reset_i || illegal_addr_i
             || (wdt_overflow_i && s_q.wdtc[BIT_WDT_RE])
             || (fbo_ev && s_q.det[BIT_FBO_RE])
             || (sbo_ev && s_q.det[BIT_SBO_RE]);
      // ****************************************
      // register writes
      // ****************************************
      if (hit(ADDR_CAUSE_FLAGS))
         s_d.cause = s_q.cause & ~(sfr_wdata_i & CAUSE_WMASK);
      if (hit(ADDR_POWER_CTRL))
         s_d.pwr = sfr_wdata_i;
      if (hit(ADDR_DETECTOR_CTRL))
         s_d.det = (sfr_wdata_i & DETECTOR_WMASK) | DETECTOR_FIXED;
      if (hit(ADDR_WDT_CTRL))
         s_d.wdtc = sfr_wdata_i;
      if (hit(ADDR_SYSFLAG_IE))
         s_d.system_flag_int_enable_reg = sfr_wdata_i;
      if (hit(ADDR_CLOCK_CTRL))
         s_d.clkc = sfr_wdata_i;
      // set wins over write-one clear
      if (wdt_overflow_i && wdt_running_i)
         s_d.cause[BIT_WDT_FLAG] = 1'b1;
      if (fbo_ev)
         s_d.cause[BIT_FBO_FLAG] = 1'b1;
      if (sbo_ev)
         s_d.cause[BIT_SBO_FLAG] = 1'b1;
      if (rtc_overflow_i)
         s_d.cause[BIT_RTC_FLAG] = 1'b1;
      if (ext_r)
         s_d.cause[BIT_EXT_FLAG] = 1'b1;
      if (soft_reset_i)
         s_d.cause[BIT_SOFT_FLAG] = 1'b1;
      s_d.irq = s_q.system_flag_int_enable_reg[BIT_SYSFLAG_IE] &&
         ((s_q.cause[BIT_FBO_FLAG] && s_q.system_flag_int_enable_reg[BIT_FBO_IE]) ||
          (s_q.cause[BIT_SBO_FLAG] && s_q.system_flag_int_enable_reg[BIT_SBO_IE]));
      wake_pd = ext_int_wake_i || keypad_wake_i || ext_r
             || (rtc_overflow_i && rtc_wake_en_i)
             || (wdt_overflow_i && s_q.wdtc[BIT_WDT_NONSTOP])
             || (sbo_ev && s_q.det[BIT_AWAKE_PD]);
      // ****************************************
      // mode sequencer
      // ****************************************
      unique case (mode_q)
         RUN: begin
            if (s_d.pwr[BIT_PDOWN]) begin
               mode_d = PDOWN;
            end else if (s_d.pwr[BIT_IDLE]) begin
               mode_d = IDLE;
            end
         end
         IDLE: begin
            if (any_int_i || rst_req) begin
               mode_d = RUN;
               s_d.pwr[BIT_IDLE] = 1'b0;
            end
         end
         PDOWN: begin
            if (wake_pd) begin
               mode_d = WAKE;
               s_d.cnt = '0;
            end
         end
         WAKE: begin
            s_d.cnt = s_q.cnt + 11'd1;
            if (s_q.cnt == 11'(WAKE_COUNT - 1)) begin
               mode_d = RUN;
               s_d.pwr[BIT_PDOWN] = 1'b0;
               s_d.pwr[BIT_IDLE]  = 1'b0;
            end
         end
      endcase
      // ****************************************
      // outputs
      // ****************************************
      s_d.gate  = (mode_d == RUN);
      s_d.hold  = (mode_d != RUN);
      s_d.osc   = (mode_d == PDOWN);
      s_d.flash = (mode_d == PDOWN) || (mode_d == WAKE);
      s_d.lvl   = (mode_d == PDOWN);
      // peripherals run off their own clocks; watchdog needs nonstop in pd
      s_d.wrun  = !in_pd || s_q.wdtc[BIT_WDT_NONSTOP];
      s_d.rdata = 8'h00;
      if (sfr_rd_i) begin
         unique case (sfr_addr_i)
            ADDR_CAUSE_FLAGS:   s_d.rdata = s_q.cause & CAUSE_WMASK;
            ADDR_POWER_CTRL:    s_d.rdata = s_q.pwr;
            ADDR_DETECTOR_CTRL: s_d.rdata = s_q.det;
            ADDR_WDT_CTRL:      s_d.rdata = s_q.wdtc;
            ADDR_SYSFLAG_IE:    s_d.rdata = s_q.system_flag_int_enable_reg;
            ADDR_CLOCK_CTRL:    s_d.rdata = s_q.clkc;
            default:            s_d.rdata = 8'h00;
         endcase
      end
      // stretched internal reset; power, watchdog, flag-enable and clock regs reset, detector reg and cause flags kept
      if (rst_req) begin
         s_d.rst_cnt = 3'(RESET_PULSE);
      end else if (s_q.rst_cnt != 3'd0) begin
         s_d.rst_cnt = s_q.rst_cnt - 3'd1;
      end
      s_d.srst = (s_d.rst_cnt != 3'd0);
      if (s_q.srst) begin
         s_d.pwr  = RST_POWER_CTRL;
         s_d.wdtc = RST_WDT_CTRL;
         s_d.system_flag_int_enable_reg = RST_SYSFLAG_IE;
         s_d.clkc = RST_CLOCK_CTRL;
         if (mode_q != WAKE) begin
            mode_d  = RUN;
            s_d.gate = 1'b1;
            s_d.hold = 1'b0;
            s_d.osc  = 1'b0;
            s_d.flash = 1'b0;
            s_d.lvl  = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         s_q         <= '0;
         s_q.det     <= RST_DETECTOR;
         s_q.gate    <= 1'b1;
         s_q.wrun    <= 1'b1;
         s_q.cause   <= RST_CAUSE;
         mode_q      <= RUN;
      end else if (clk_en_i) begin
         s_q    <= s_d;
         mode_q <= mode_d;
      end
   end

   assign sfr_rdata_o       = s_q.rdata;
   assign sys_reset_o       = s_q.srst;
   assign cpu_clk_gate_o    = s_q.gate;
   assign osc_stop_o        = s_q.osc;
   assign flash_pwr_down_o  = s_q.flash;
   assign pins_hold_o       = s_q.hold;
   assign force_level_int_o = s_q.lvl;
   assign sysflag_irq_o     = s_q.irq;
   assign wdt_run_o         = s_q.wrun;
   assign clk_div_sel_o     = s_q.clkc[2:0];
   assign osc_src_sel_o     = s_q.clkc[5:4];
   assign sbo_level_o       = s_q.det[5:4];
endmodule
`default_nettype wire

// File: rst_pwr_ctrl_properties.sv
// port assertions for the reset and power mode controller
`default_nettype none
module rst_pwr_ctrl_checker
   import rst_pwr_pkg::*;
(
   input wire logic       core_clk_i,
   input wire logic       rstn_i,
   input wire logic       sfr_wr_i,
   input wire logic       sfr_rd_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic       illegal_addr_i,
   input wire logic       any_int_i,
   input wire logic [7:0] sfr_rdata_o,
   input wire logic       sys_reset_o,
   input wire logic       cpu_clk_gate_o,
   input wire logic       osc_stop_o,
   input wire logic       flash_pwr_down_o,
   input wire logic       pins_hold_o,
   input wire logic       force_level_int_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   wire pwr_wr   = sfr_wr_i && sfr_addr_i == ADDR_POWER_CTRL;
   wire cause_rd = sfr_rd_i && sfr_addr_i == ADDR_CAUSE_FLAGS;
   // cycles spent waking; a counter, since the wait is too long to unroll
   logic [10:0] wake_cnt;
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i || !flash_pwr_down_o || osc_stop_o) begin
         wake_cnt <= 11'h000;
      end else if (wake_cnt != 11'h7FF) begin
         wake_cnt <= wake_cnt + 11'h001;
      end
   end
   // ********
   // properties
   // ********
   property p_mask; cause_rd |=> (sfr_rdata_o & 8'h28) == 8'h00; endproperty
   a_mask: assert property (p_mask) else $error("reserved cause bits read set");
   property p_illegal; illegal_addr_i |-> ##[1:2] sys_reset_o; endproperty
   a_illegal: assert property (p_illegal) else $error("no reset on bad fetch");
   property p_hold; $rose(sys_reset_o) |-> sys_reset_o[*4]; endproperty
   a_hold: assert property (p_hold) else $error("system reset too short");
   property p_pd_in; pwr_wr && sfr_wdata_i[1] |-> ##[1:2] osc_stop_o; endproperty
   a_pd_in: assert property (p_pd_in) else $error("power-down not entered");
   property p_pd_state;
      osc_stop_o |-> flash_pwr_down_o && force_level_int_o && !cpu_clk_gate_o;
   endproperty
   a_pd_state: assert property (p_pd_state) else $error("power-down outputs wrong");
   // oscillator must settle before the cpu sees a clock
   property p_wake;
      $fell(flash_pwr_down_o) && !$past(osc_stop_o) |-> wake_cnt == 11'(WAKE_COUNT);
   endproperty
   a_wake: assert property (p_wake) else $error("wake delay wrong");
   property p_wake_gate; flash_pwr_down_o && !osc_stop_o |-> !cpu_clk_gate_o; endproperty
   a_wake_gate: assert property (p_wake_gate) else $error("cpu clocked while waking");
   property p_idle_in;
      pwr_wr && sfr_wdata_i[0] |-> ##[1:2] (pins_hold_o && !cpu_clk_gate_o);
   endproperty
   a_idle_in: assert property (p_idle_in) else $error("idle not entered");
   property p_idle_out;
      pins_hold_o && !flash_pwr_down_o && any_int_i |-> ##[1:3] !pins_hold_o;
   endproperty
   a_idle_out: assert property (p_idle_out) else $error("idle not left");
   c_wake: cover property ($fell(osc_stop_o));
   c_reset: cover property ($rose(sys_reset_o));
   c_idle: cover property ($fell(pins_hold_o) && !osc_stop_o);
endmodule
bind rst_pwr_ctrl rst_pwr_ctrl_checker chk (.core_clk_i, .rstn_i, .sfr_wr_i, .sfr_rd_i,
   .sfr_addr_i, .sfr_wdata_i, .illegal_addr_i, .any_int_i, .sfr_rdata_o, .sys_reset_o,
   .cpu_clk_gate_o, .osc_stop_o, .flash_pwr_down_o, .pins_hold_o, .force_level_int_o);
`default_nettype wire

// File: rst_pwr_ctrl_tb.sv
// self-checking bench for the reset and power mode controller
`default_nettype none
module rst_pwr_ctrl_tb
   import rst_pwr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic       core_clk_i = 0, rstn_i = 0, clk_en_i = 1, sfr_wr_i = 0, sfr_rd_i = 0;
   logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o;
   logic       ext_reset_i = 0, soft_reset_i = 0, illegal_addr_i = 0, wdt_overflow_i = 0;
   logic       wdt_running_i = 1, rtc_overflow_i = 0, rtc_wake_en_i = 0, any_int_i = 0;
   logic       fixed_brownout_i = 0, selectable_brownout_i = 0, ext_int_wake_i = 0;
   logic       keypad_wake_i = 0, sys_reset_o, cpu_clk_gate_o, osc_stop_o, flash_pwr_down_o;
   logic       pins_hold_o, force_level_int_o, sysflag_irq_o, wdt_run_o;
   logic [2:0] clk_div_sel_o;
   logic [1:0] osc_src_sel_o, sbo_level_o;
   int         failures = 0, total_checks = 0, cycles = 0;
   always #20 core_clk_i = ~core_clk_i;
   rst_pwr_ctrl dut (.*);
   // ********
   // helpers
   // ********
   task automatic check(input string what, input logic [7:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask
   // strobes drop with a gap cycle so back-to-back calls never re-drive in one step
   task automatic wr(input logic [7:0] a, d);
      {sfr_wr_i, sfr_addr_i, sfr_wdata_i} = {1'b1, a, d};
      cyc(1);
      sfr_wr_i = 0;
      cyc(1);
   endtask
   task automatic rd(input string what, input logic [7:0] a, exp);
      {sfr_rd_i, sfr_addr_i} = {1'b1, a};
      cyc(1);
      check(what, sfr_rdata_o, exp);
      sfr_rd_i = 0;
      cyc(1);
   endtask
   task automatic pulse(ref logic s, input int n);
      s = 1;
      cyc(n);
      s = 0;
      cyc(1);
   endtask
   task automatic expect_reset(input string what);
      check(what, sys_reset_o, 1);
      for (int i = 0; i < 20 && sys_reset_o === 1'b1; i++) cyc(1);
      check("reset ends", sys_reset_o, 0);
   endtask
   task automatic stop_test();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles > 10000) begin
         failures++;
         stop_test();
      end
   end
   task automatic t_flags();
      rd("detector", ADDR_DETECTOR_CTRL, RST_DETECTOR);
      rd("unmapped", 8'h00, 8'h00);
      wr(ADDR_CLOCK_CTRL, 8'h35);
      check("divider", clk_div_sel_o, 8'h05);
      check("osc select", osc_src_sel_o, 8'h03);
      pulse(wdt_overflow_i, 1);
      check("no wdt reset", sys_reset_o, 0);
      rd("wdt flag", ADDR_CAUSE_FLAGS, 8'h01);
      wr(ADDR_CAUSE_FLAGS, 8'h00);
      rd("write zero", ADDR_CAUSE_FLAGS, 8'h01);
      wr(ADDR_CAUSE_FLAGS, 8'h01);
      rd("write one", ADDR_CAUSE_FLAGS, 8'h00);
      wr(ADDR_WDT_CTRL, 8'h80);
      pulse(wdt_overflow_i, 1);
      expect_reset("wdt reset");
      pulse(illegal_addr_i, 1);
      expect_reset("bad fetch");
      pulse(soft_reset_i, 1);
      expect_reset("soft");
      pulse(ext_reset_i, 4);
      expect_reset("external");
      rd("kept flags", ADDR_CAUSE_FLAGS, 8'hC1);
      wr(ADDR_CAUSE_FLAGS, 8'hFF);
      $display("flags test done");
   endtask
   task automatic t_brownout();
      wr(ADDR_DETECTOR_CTRL, 8'h35);
      check("bo level", sbo_level_o, 8'h03);
      wr(ADDR_SYSFLAG_IE, 8'h03);
      pulse(fixed_brownout_i, 4);
      check("flag irq", sysflag_irq_o, 1);
      wr(ADDR_DETECTOR_CTRL, 8'h01);
      pulse(selectable_brownout_i, 4);
      rd("disabled", ADDR_CAUSE_FLAGS, 8'h02);
      wr(ADDR_DETECTOR_CTRL, 8'h0D);
      pulse(selectable_brownout_i, 4);
      expect_reset("sel reset");
      wr(ADDR_DETECTOR_CTRL, 8'h03);
      pulse(fixed_brownout_i, 4);
      expect_reset("fixed reset");
      rd("bo flags", ADDR_CAUSE_FLAGS, 8'h06);
      wr(ADDR_CAUSE_FLAGS, 8'hFF);
      $display("brownout test done");
   endtask
   task automatic t_idle();
      wr(ADDR_POWER_CTRL, 8'h01);
      check("pins hold", pins_hold_o, 1);
      check("wdt idle run", wdt_run_o, 1);
      pulse(any_int_i, 1);
      rd("idle bit", ADDR_POWER_CTRL, 8'h00);
      check("cpu runs", cpu_clk_gate_o, 1);
      $display("idle test done");
   endtask
   task automatic t_pdown(input int src);
      int n;
      rtc_wake_en_i = (src == 2);
      cyc(REENTRY_CYCLES);
      if (src == 3) wr(ADDR_WDT_CTRL, 8'h40);
      wr(ADDR_POWER_CTRL, 8'h02);
      check("osc stop", osc_stop_o, 1);
      check("wdt pd run", wdt_run_o, src == 3);
      pulse(any_int_i, 1);
      check("stays down", osc_stop_o, 1);
      if (src == 0) pulse(keypad_wake_i, 1);
      else if (src == 1) pulse(ext_int_wake_i, 1);
      else if (src == 2) pulse(rtc_overflow_i, 1);
      else pulse(wdt_overflow_i, 1);
      check("osc restart", osc_stop_o, 0);
      n = 0;
      while (cpu_clk_gate_o !== 1'b1 && n < 1200) begin
         cyc(1);
         n++;
      end
      check("wake count", n >= WAKE_COUNT - 6 && n <= WAKE_COUNT + 4, 1);
      rd("pd bit", ADDR_POWER_CTRL, 8'h00);
      $display("power-down test %0d done", src);
   endtask
   initial begin
      cyc(4);
      rstn_i = 1;
      cyc(1);
      t_flags();
      t_brownout();
      t_idle();
      for (int s = 0; s < 4; s++) t_pdown(s);
      stop_test();
   end
endmodule
`default_nettype wire
